// ==== pcsr_pkg.sv ====
// constants and types for the receive decoder
package pcsr_pkg;
  localparam logic [7:0]  ADDR_CTRL      = 8'h00;
  localparam logic [7:0]  ADDR_STATUS    = 8'h04;
  localparam logic [7:0]  ADDR_FRAMES    = 8'h08;
  localparam logic [7:0]  ADDR_ERRORS    = 8'h0c;
  localparam int          CTRL_POL_EN    = 0;
  localparam int          CTRL_SLAVE     = 1;
  localparam int          CTRL_HALF_DPX  = 2;
  localparam int          CTRL_POL_FORCE = 3;
  localparam logic [3:0]  CTRL_RESET     = 4'h5;
  localparam int          ST_FRAME_VALID = 0;
  localparam int          ST_FRAME_ERR   = 1;
  localparam int          ST_SCR_LOCK    = 2;
  localparam int          ST_POL_INV     = 3;
  localparam int          ST_LOC_OK      = 4;
  localparam int          ST_MAX_EXP     = 5;
  // ternary symbol coding: 00 zero, 01 plus one, 11 minus one
  localparam logic [1:0]  SYM_ZERO       = 2'h0;
  localparam logic [1:0]  SYM_POS        = 2'h1;
  localparam logic [1:0]  SYM_NEG        = 2'h3;
  localparam int          RCV_MAX_CYCLES = 36000;
  localparam int          RCV_MAX_TOL    = 1800;
  localparam int          SCR_LEN        = 33;
  localparam int          SCR_TAP        = 13;
  localparam int          LOCK_SYMBOLS   = 64;
  localparam int          MON_SYMBOLS    = 2048;
  localparam int          NIB_DEPTH      = 4;
  typedef enum logic [1:0] {
    RX_IDLE,
    RX_IDLE_ESC,
    RX_FRAME,
    RX_FRAME_ESC
  } pcsr_rx_state_type;
  typedef enum logic [1:0] {
    SY_ACQUIRE,
    SY_MONITOR,
    SY_LOCKED
  } pcsr_sync_state_type;
endpackage

// ==== pcsr_decoder.sv ====
// receive decoder: descrambler, delimiters, polarity, nibble packing, apb registers
`timescale 1ns/1ps
module pcsr_decoder #(
  parameter int RCV_MAX = pcsr_pkg::RCV_MAX_CYCLES
) (
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        sym_stb_i,
  input  wire logic [1:0]  received_symbol_a_i,
  input  wire logic [1:0]  received_symbol_b_i,
  input  wire logic        loc_rcvr_ok_i,
  input  wire logic        rem_rcvr_ok_i,
  input  wire logic        mii_tick_i,
  input  wire logic [1:0]  transmitted_symbol_a_i,
  input  wire logic [1:0]  transmitted_symbol_b_i,
  output logic      [1:0]  tx_sym_a_o,
  output logic      [1:0]  tx_sym_b_o,
  output logic             tx_en_o,
  output logic             rem_rcvr_ok_o,
  output logic             scr_status_o,
  output logic             rx_clk_recovered_o,
  output logic      [3:0]  rxd_o,
  output logic             tribit_valid_o,
  output logic             rx_er_o
);

  function automatic logic [1:0] neg_sym(input logic [1:0] s);
    // two's complement: zero stays zero, plus one and minus one swap
    neg_sym = ~s + 2'h1;
  endfunction

  // pair of ternary symbols to three bits; (0,0) is the control escape
  function automatic logic [2:0] pair_bits(input logic [1:0] a, input logic [1:0] b);
    logic [1:0] ia;
    logic [1:0] ib;
    ia = (a == pcsr_pkg::SYM_ZERO) ? 2'h0 : ((a == pcsr_pkg::SYM_POS) ? 2'h1 : 2'h2);
    ib = (b == pcsr_pkg::SYM_ZERO) ? 2'h0 : ((b == pcsr_pkg::SYM_POS) ? 2'h1 : 2'h2);
    pair_bits = 3'(4'(ia) * 4'h3 + 4'(ib) - 4'h1);
  endfunction

  // pin synchronisers, two flops each
  logic [9:0] pin_m_r;
  logic [9:0] pin_s_r;
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      pin_m_r <= 10'h000;
      pin_s_r <= 10'h000;
    end
    else
    begin
      pin_m_r <= {rem_rcvr_ok_i, loc_rcvr_ok_i, received_symbol_b_i,
                  received_symbol_a_i, sym_stb_i, 3'h0};
      pin_s_r <= pin_m_r;
    end
  end

  logic       stb_s;
  logic [1:0] ra_s;
  logic [1:0] rb_s;
  logic       loc_ok_s;
  logic       rem_ok_s;
  assign stb_s    = pin_s_r[3];
  assign ra_s     = pin_s_r[5:4];
  assign rb_s     = pin_s_r[7:6];
  assign loc_ok_s = pin_s_r[8];
  assign rem_ok_s = pin_s_r[9];

  // apb registers
  logic [3:0]  ctrl_r;
  logic [15:0] frames_r;
  logic [15:0] errors_r;
  logic        pol_inv_r;
  logic        frame_valid_flag_r;
  logic        frame_error_flag_r;
  logic        max_exp_r;
  logic        apb_wr;
  logic        mapped;
  assign apb_wr    = psel_i & penable_i & pwrite_i;
  assign mapped    = (paddr_i == pcsr_pkg::ADDR_CTRL) | (paddr_i == pcsr_pkg::ADDR_STATUS) |
                     (paddr_i == pcsr_pkg::ADDR_FRAMES) | (paddr_i == pcsr_pkg::ADDR_ERRORS);
  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i & penable_i & ~mapped;

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      ctrl_r <= pcsr_pkg::CTRL_RESET;
    else if (apb_wr && paddr_i == pcsr_pkg::ADDR_CTRL)
      ctrl_r <= pwdata_i[3:0];
  end

  logic sync_ok;
  always_comb
  begin
    case (paddr_i)
      pcsr_pkg::ADDR_CTRL:   prdata_o = {28'h0, ctrl_r};
      pcsr_pkg::ADDR_STATUS: prdata_o = {26'h0, max_exp_r, loc_ok_s, pol_inv_r, sync_ok,
                                         frame_error_flag_r, frame_valid_flag_r};
      pcsr_pkg::ADDR_FRAMES: prdata_o = {16'h0, frames_r};
      pcsr_pkg::ADDR_ERRORS: prdata_o = {16'h0, errors_r};
      default:               prdata_o = 32'h0;
    endcase
  end

  // polarity corrected receive symbols
  logic [1:0] ra_c;
  logic [1:0] rb_c;
  assign ra_c = pol_inv_r ? neg_sym(ra_s) : ra_s;
  assign rb_c = pol_inv_r ? neg_sym(rb_s) : rb_s;

  // side-stream descrambler
  logic [pcsr_pkg::SCR_LEN-1:0] scr_r;
  logic                         scr_next;
  logic [2:0]                   side_stream_bits;
  assign scr_next         = scr_r[pcsr_pkg::SCR_TAP-1] ^ scr_r[pcsr_pkg::SCR_LEN-1];
  assign side_stream_bits = {scr_r[6] ^ scr_r[16], scr_r[3] ^ scr_r[8], scr_r[0]};

  pcsr_pkg::pcsr_sync_state_type sy_r;
  pcsr_pkg::pcsr_rx_state_type   rx_r;
  logic [11:0] mon_r;
  logic [6:0]  agree_r;
  logic        idle_bit;
  logic        b_ok;
  assign idle_bit = (ra_c == pcsr_pkg::SYM_ZERO);
  assign b_ok     = (rb_c == pcsr_pkg::SYM_ZERO) ||
                    ((rb_c == pcsr_pkg::SYM_POS) == ~side_stream_bits[1]);
  assign sync_ok  = (sy_r == pcsr_pkg::SY_LOCKED);
  assign scr_status_o = sync_ok;

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      scr_r <= '0;
    else if (stb_s)
    begin
      if (sy_r == pcsr_pkg::SY_ACQUIRE)
        scr_r <= {scr_r[pcsr_pkg::SCR_LEN-2:0], idle_bit};
      else
        scr_r <= {scr_r[pcsr_pkg::SCR_LEN-2:0], scr_next};
    end
  end

  // acquisition, lock monitor and polarity search
  always_ff @(posedge mclk_i)
  begin
    if (rst_i || !loc_ok_s)
    begin
      sy_r      <= pcsr_pkg::SY_ACQUIRE;
      mon_r     <= 12'h000;
      agree_r   <= 7'h00;
      // forced polarity holds even without local receiver ok
      pol_inv_r <= !rst_i && !ctrl_r[pcsr_pkg::CTRL_POL_EN] &&
                   ctrl_r[pcsr_pkg::CTRL_POL_FORCE];
    end
    else
    begin
      if (!ctrl_r[pcsr_pkg::CTRL_POL_EN])
        pol_inv_r <= ctrl_r[pcsr_pkg::CTRL_POL_FORCE];
      if (stb_s)
      begin
        case (sy_r)
          pcsr_pkg::SY_ACQUIRE:
          begin
            mon_r <= mon_r + 12'h001;
            if (mon_r == 12'(pcsr_pkg::SCR_LEN - 1))
            begin
              sy_r    <= pcsr_pkg::SY_MONITOR;
              agree_r <= 7'h00;
            end
          end
          pcsr_pkg::SY_MONITOR:
          begin
            mon_r <= mon_r + 12'h001;
            if (rx_r != pcsr_pkg::RX_IDLE)
              agree_r <= agree_r;
            else if (scr_next == idle_bit && b_ok)
              agree_r <= agree_r + 7'h01;
            else
              agree_r <= 7'h00;
            if (agree_r == 7'(pcsr_pkg::LOCK_SYMBOLS - 1))
              sy_r <= pcsr_pkg::SY_LOCKED;
            else if (mon_r == 12'(pcsr_pkg::MON_SYMBOLS - 1))
            begin
              sy_r  <= pcsr_pkg::SY_ACQUIRE;
              mon_r <= 12'h000;
              if (ctrl_r[pcsr_pkg::CTRL_POL_EN])
                pol_inv_r <= ~pol_inv_r;
            end
          end
          pcsr_pkg::SY_LOCKED:
          begin
            if (rx_r == pcsr_pkg::RX_IDLE && scr_next != idle_bit)
            begin
              sy_r  <= pcsr_pkg::SY_ACQUIRE;
              mon_r <= 12'h000;
            end
          end
          default:
            sy_r <= pcsr_pkg::SY_ACQUIRE;
        endcase
      end
    end
  end

  // transmit polarity, duplex step and remote status
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      tx_sym_a_o    <= pcsr_pkg::SYM_ZERO;
      tx_sym_b_o    <= pcsr_pkg::SYM_ZERO;
      tx_en_o       <= 1'b0;
      rem_rcvr_ok_o <= 1'b0;
    end
    else
    begin
      tx_sym_a_o    <= pol_inv_r ? neg_sym(transmitted_symbol_a_i) : transmitted_symbol_a_i;
      tx_sym_b_o    <= pol_inv_r ? neg_sym(transmitted_symbol_b_i) : transmitted_symbol_b_i;
      tx_en_o       <= ~ctrl_r[pcsr_pkg::CTRL_SLAVE] | ~ctrl_r[pcsr_pkg::CTRL_HALF_DPX];
      rem_rcvr_ok_o <= rem_ok_s & ~ctrl_r[pcsr_pkg::CTRL_HALF_DPX];
    end
  end

  // mii timing source follows role
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      rx_clk_recovered_o <= 1'b0;
    else
      rx_clk_recovered_o <= ctrl_r[pcsr_pkg::CTRL_SLAVE];
  end

  // delimiter state machine and nibble packer
  logic [2:0]  tribit;
  logic        esc;
  logic        tribit_valid;
  logic [5:0]  acc_r;
  logic [2:0]  acc_n_r;
  logic [15:0] max_r;
  logic [3:0]  fifo_r [pcsr_pkg::NIB_DEPTH];
  logic        fifo_er_r [pcsr_pkg::NIB_DEPTH];
  logic [1:0]  wr_r;
  logic [1:0]  rd_r;
  logic [2:0]  cnt_r;
  logic        push;
  logic        pop;
  logic [3:0]  push_nib;
  logic        push_er;
  assign esc    = (ra_c == pcsr_pkg::SYM_ZERO) && (rb_c == pcsr_pkg::SYM_ZERO);
  assign tribit = pair_bits(ra_c, rb_c) ^ side_stream_bits;
  assign tribit_valid = stb_s && rx_r == pcsr_pkg::RX_FRAME && !esc;
  assign pop    = mii_tick_i && cnt_r != 3'h0;

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      rx_r               <= pcsr_pkg::RX_IDLE;
      frame_valid_flag_r <= 1'b0;
      frame_error_flag_r <= 1'b0;
      max_r              <= 16'h0000;
      max_exp_r          <= 1'b0;
      frames_r           <= 16'h0000;
      errors_r           <= 16'h0000;
    end
    else if (!loc_ok_s)
    begin
      rx_r               <= pcsr_pkg::RX_IDLE;
      frame_valid_flag_r <= 1'b0;
      frame_error_flag_r <= 1'b0;
    end
    else if (stb_s)
    begin
      max_r <= frame_valid_flag_r ? max_r + 16'h0001 : 16'h0000;
      case (rx_r)
        pcsr_pkg::RX_IDLE:
        begin
          frame_error_flag_r <= 1'b0;
          if (esc)
            rx_r <= pcsr_pkg::RX_IDLE_ESC;
        end
        pcsr_pkg::RX_IDLE_ESC:
        begin
          if (ra_c == pcsr_pkg::SYM_POS && rb_c == pcsr_pkg::SYM_POS)
          begin
            rx_r               <= pcsr_pkg::RX_FRAME;
            frame_valid_flag_r <= 1'b1;
            frames_r           <= frames_r + 16'h0001;
          end
          else
          begin
            rx_r               <= pcsr_pkg::RX_IDLE;
            frame_error_flag_r <= 1'b1;
            errors_r           <= errors_r + 16'h0001;
          end
        end
        pcsr_pkg::RX_FRAME:
        begin
          if (max_r == 16'(RCV_MAX - 1))
          begin
            rx_r               <= pcsr_pkg::RX_IDLE;
            frame_valid_flag_r <= 1'b0;
            frame_error_flag_r <= 1'b1;
            max_exp_r          <= 1'b1;
          end
          else if (esc)
            rx_r <= pcsr_pkg::RX_FRAME_ESC;
        end
        pcsr_pkg::RX_FRAME_ESC:
        begin
          rx_r               <= pcsr_pkg::RX_IDLE;
          frame_valid_flag_r <= 1'b0;
          if (!(ra_c == pcsr_pkg::SYM_NEG && rb_c == pcsr_pkg::SYM_NEG))
          begin
            frame_error_flag_r <= 1'b1;
            errors_r           <= errors_r + 16'h0001;
          end
        end
        default:
          rx_r <= pcsr_pkg::RX_IDLE;
      endcase
    end
  end

  // three-bit words into nibbles, lsb first
  always_comb
  begin
    push     = 1'b0;
    push_nib = 4'h0;
    push_er  = frame_error_flag_r;
    if (tribit_valid && acc_n_r != 3'h0 && cnt_r != 3'(pcsr_pkg::NIB_DEPTH))
    begin
      push     = 1'b1;
      push_nib = 4'({tribit, acc_r[2:0]} >> (3'h3 - (acc_n_r - 3'h1)));
    end
    case (acc_n_r)
      3'h1:    push_nib = {tribit, acc_r[0]};
      3'h2:    push_nib = {tribit[1:0], acc_r[1:0]};
      3'h3:    push_nib = {tribit[0], acc_r[2:0]};
      default: push_nib = push_nib;
    endcase
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i || rx_r != pcsr_pkg::RX_FRAME)
    begin
      acc_r   <= 6'h00;
      acc_n_r <= 3'h0;
    end
    else if (tribit_valid)
    begin
      if (acc_n_r == 3'h0)
      begin
        acc_r   <= {3'h0, tribit};
        acc_n_r <= 3'h3;
      end
      else
      begin
        acc_r   <= 6'({3'h0, tribit} >> (3'h4 - acc_n_r));
        acc_n_r <= acc_n_r - 3'h1;
      end
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      wr_r  <= 2'h0;
      rd_r  <= 2'h0;
      cnt_r <= 3'h0;
    end
    else
    begin
      if (push)
      begin
        fifo_r[wr_r]    <= push_nib;
        fifo_er_r[wr_r] <= push_er;
        wr_r            <= wr_r + 2'h1;
      end
      if (pop)
        rd_r <= rd_r + 2'h1;
      cnt_r <= cnt_r + {2'h0, push} - {2'h0, pop};
    end
  end

  // mii side, one nibble per tick
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      rxd_o   <= 4'h0;
      tribit_valid_o <= 1'b0;
      rx_er_o <= 1'b0;
    end
    else if (mii_tick_i)
    begin
      rxd_o   <= pop ? fifo_r[rd_r] : 4'h0;
      tribit_valid_o <= pop;
      rx_er_o <= pop & fifo_er_r[rd_r];
    end
  end

endmodule

// ==== pcsr_decoder_checker.sv ====
// port assertions for the receive decoder
`timescale 1ns/1ps
module pcsr_decoder_checker (
  input wire logic        mclk_i,
  input wire logic        rst_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [7:0]  paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic        sym_stb_i,
  input wire logic        loc_rcvr_ok_i,
  input wire logic        rem_rcvr_ok_i,
  input wire logic        mii_tick_i,
  input wire logic [1:0]  transmitted_symbol_a_i,
  input wire logic [1:0]  transmitted_symbol_b_i,
  input wire logic [1:0]  tx_sym_a_o,
  input wire logic [1:0]  tx_sym_b_o,
  input wire logic        tx_en_o,
  input wire logic        rem_rcvr_ok_o,
  input wire logic        scr_status_o,
  input wire logic        rx_clk_recovered_o,
  input wire logic [3:0]  rxd_o,
  input wire logic        tribit_valid_o,
  input wire logic        rx_er_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);
  logic mapped;
  assign mapped = paddr_i inside {8'h00, 8'h04, 8'h08, 8'h0c};
  sequence apb_acc;
    psel_i && penable_i;
  endsequence
  sequence no_wr;
    !(psel_i && penable_i && pwrite_i) [*2];
  endsequence
  sequence quiet_sym;
    !sym_stb_i && loc_rcvr_ok_i [*6];
  endsequence
  apb_ready_a: assert property (apb_acc |-> pready_o)
    else $error("access without ready");
  unmapped_err_a: assert property (apb_acc and !mapped |-> pslverr_o && prdata_o == 32'h0)
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (apb_acc and mapped |-> !pslverr_o)
    else $error("mapped access refused");
  mii_hold_a: assert property (!mii_tick_i |=> $stable(tribit_valid_o) && $stable(rxd_o) && $stable(rx_er_o))
    else $error("mii output moved without tick");
  rem_false_a: assert property (!rem_rcvr_ok_i [*4] |=> !rem_rcvr_ok_o)
    else $error("remote status true without input");
  tx_sign_a: assert property (1'b1 |=>
    (tx_sym_a_o == $past(transmitted_symbol_a_i) && tx_sym_b_o == $past(transmitted_symbol_b_i))
    || (tx_sym_a_o == -$past(transmitted_symbol_a_i) && tx_sym_b_o == -$past(transmitted_symbol_b_i)))
    else $error("tx symbols not passed or negated");
  cfg_hold_a: assert property (no_wr |=> $stable(rx_clk_recovered_o) && $stable(tx_en_o))
    else $error("config output moved without write");
  scr_hold_a: assert property (quiet_sym |=> $stable(scr_status_o))
    else $error("lock moved without symbol");
endmodule

// ==== pcsr_mac_model.sv ====
// mac side model: paces mii slots and counts nibbles per frame
`timescale 1ns/1ps
module pcsr_mac_model (
  input  wire logic mclk_i,
  input  wire logic rst_i,
  input  wire logic slow_i,
  input  wire logic tribit_valid_i,
  output logic      mii_tick_o,
  output int        frames_o,
  output int        nibs_o
);
  int   cnt;
  int   cur;
  int   gap;
  // slot every second clock, or every fourth when slow
  always_ff @(posedge mclk_i)
  begin
    if (rst_i || cnt == 0)
      cnt <= slow_i ? 3 : 1;
    else
      cnt <= cnt - 1;
    mii_tick_o <= !rst_i && cnt == 0;
  end
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      frames_o <= 0;
      nibs_o <= 0;
      cur <= 0;
      gap <= 0;
    end
    else if (mii_tick_o)
    begin
      // buffer may empty between nibbles; frame ends after twelve idle slots
      if (tribit_valid_i)
      begin
        cur <= cur + 1;
        gap <= 0;
      end
      else if (cur != 0 && gap == 11)
      begin
        frames_o <= frames_o + 1;
        nibs_o <= cur;
        cur <= 0;
      end
      else
        gap <= gap + 1;
    end
  end
endmodule

// ==== pcs_receive_decoder_test.sv ====
// self-checking bench for the receive decoder
`timescale 1ns/1ps
module pcs_receive_decoder_test;
  localparam logic [1:0] SP = pcsr_pkg::SYM_POS;
  localparam logic [1:0] SN = pcsr_pkg::SYM_NEG;
  logic        mclk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        stb = 1'b0;
  logic [1:0]  sa = 2'h0;
  logic [1:0]  sb = 2'h0;
  logic        lok = 1'b0;
  logic        rok = 1'b0;
  logic        slow = 1'b0;
  logic        tick;
  logic [1:0]  ta = 2'h0;
  logic [1:0]  tb2 = 2'h0;
  logic [1:0]  txa;
  logic [1:0]  txb;
  logic        txen;
  logic        remo;
  logic        rck;
  logic        scs;
  logic [3:0]  rxd;
  logic        rxdv;
  logic        rxer;
  logic [31:0] rng = 32'h1472;
  logic [31:0] q;
  logic        e;
  logic [3:0]  cfg [5] = '{4'h0, 4'h2, 4'h4, 4'h6, 4'h8};
  int          lens [4] = '{2, 3, 5, 8};
  int          exp_q [$];
  int          errors = 0;
  int          cmp_count = 0;
  int          frames;
  int          nibs;
  int          nfr = 0;
  int          f0;
  int          n;
  always #25 mclk_i = ~mclk_i;
  pcsr_decoder #(.RCV_MAX(64)) uut (
    .mclk_i(mclk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .sym_stb_i(stb), .received_symbol_a_i(sa), .received_symbol_b_i(sb),
    .loc_rcvr_ok_i(lok), .rem_rcvr_ok_i(rok), .mii_tick_i(tick),
    .transmitted_symbol_a_i(ta), .transmitted_symbol_b_i(tb2), .tx_sym_a_o(txa),
    .tx_sym_b_o(txb), .tx_en_o(txen), .rem_rcvr_ok_o(remo), .scr_status_o(scs),
    .rx_clk_recovered_o(rck), .rxd_o(rxd), .tribit_valid_o(rxdv), .rx_er_o(rxer));
  pcsr_mac_model mac (.mclk_i(mclk_i), .rst_i(rst_i), .slow_i(slow), .tribit_valid_i(rxdv),
    .mii_tick_o(tick), .frames_o(frames), .nibs_o(nibs));
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [1:0] sy(input logic [7:0] k);
    return (k % 3 == 0) ? 2'h0 : (k % 3 == 1) ? SP : SN;
  endfunction
  task automatic test_done();
    $display("comparisons %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic hang();
    errors++;
    test_done();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge mclk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk_i);
    penable <= 1'b1;
    do
    begin
      @(posedge mclk_i);
      k++;
      if (k > 20)
        hang();
    end
    while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask
  task automatic st_bit(input int b, input logic exp);
    apb(1'b0, pcsr_pkg::ADDR_STATUS, 32'h0);
    chk_bit(q[b], exp);
  endtask
  task automatic sym(input logic [1:0] a, input logic [1:0] b);
    @(posedge mclk_i);
    sa <= a;
    sb <= b;
    @(posedge mclk_i);
    stb <= 1'b1;
    @(posedge mclk_i);
    stb <= 1'b0;
    repeat (3) @(posedge mclk_i);
  endtask
  // random pair that is never an escape
  task automatic dat();
    logic [1:0] a;
    logic [1:0] b;
    rng = lfsr(rng);
    a = sy(rng[7:0]);
    b = sy(rng[15:8]);
    if (a == 2'h0 && b == 2'h0)
      b = SP;
    sym(a, b);
  endtask
  task automatic frame(input int len, input logic [1:0] end_b);
    sym(2'h0, 2'h0);
    sym(SP, SP);
    st_bit(pcsr_pkg::ST_FRAME_VALID, lok);
    repeat (len) dat();
    sym(2'h0, 2'h0);
    sym(SN, end_b);
    st_bit(pcsr_pkg::ST_FRAME_VALID, 1'b0);
  endtask
  initial
  begin
    repeat (20) @(posedge mclk_i);
    rst_i <= 1'b0;
    rd(pcsr_pkg::ADDR_CTRL, {28'h0, pcsr_pkg::CTRL_RESET});
    rd(pcsr_pkg::ADDR_STATUS, 32'h0);
    rd(pcsr_pkg::ADDR_FRAMES, 32'h0);
    apb(1'b1, pcsr_pkg::ADDR_ERRORS, 32'hffff);
    rd(pcsr_pkg::ADDR_ERRORS, 32'h0);
    rd(8'h10, 32'h0);
    chk_bit(e, 1'b1);
    foreach (cfg[i])
    begin
      apb(1'b1, pcsr_pkg::ADDR_CTRL, {28'h0, cfg[i]});
      rng = lfsr(rng);
      rok <= rng[0];
      ta <= sy(rng[7:0]);
      tb2 <= sy(rng[15:8]);
      repeat (5) @(posedge mclk_i);
      chk_bit(txen, !(cfg[i][1] && cfg[i][2]));
      chk_bit(remo, rng[0] && !cfg[i][2]);
      chk_bit(rck, cfg[i][1]);
      chk({28'h0, txa, txb}, cfg[i][3] ? {28'h0, -ta, -tb2} : {28'h0, ta, tb2});
    end
    apb(1'b1, pcsr_pkg::ADDR_CTRL, 32'h0);
    frame(3, SN);
    rd(pcsr_pkg::ADDR_FRAMES, 32'h0);
    lok <= 1'b1;
    repeat (6) dat();
    foreach (lens[i])
    begin
      slow <= (i == 2);
      f0 = frames;
      exp_q.push_back(3 * lens[i] / 4);
      frame(lens[i], SN);
      nfr++;
      rd(pcsr_pkg::ADDR_FRAMES, nfr);
      n = 0;
      while (frames == f0)
      begin
        @(posedge mclk_i);
        n++;
        if (n > 300)
          hang();
      end
      chk(nibs, exp_q.pop_front());
      dat();
    end
    // random idle pairs never agree 64 times running
    chk_bit(scs, 1'b0);
    sym(2'h0, 2'h0);
    sym(SN, SP);
    st_bit(pcsr_pkg::ST_FRAME_ERR, 1'b1);
    rd(pcsr_pkg::ADDR_ERRORS, 32'h1);
    dat();
    st_bit(pcsr_pkg::ST_FRAME_ERR, 1'b0);
    frame(4, SP);
    st_bit(pcsr_pkg::ST_FRAME_ERR, 1'b1);
    sym(2'h0, 2'h0);
    sym(SP, SP);
    repeat (70) dat();
    st_bit(pcsr_pkg::ST_MAX_EXP, 1'b1);
    st_bit(pcsr_pkg::ST_FRAME_VALID, 1'b0);
    test_done();
  end
endmodule
bind pcsr_decoder pcsr_decoder_checker chk (
  .mclk_i(mclk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .prdata_o(prdata_o), .pready_o(pready_o),
  .pslverr_o(pslverr_o), .sym_stb_i(sym_stb_i), .loc_rcvr_ok_i(loc_rcvr_ok_i),
  .rem_rcvr_ok_i(rem_rcvr_ok_i), .mii_tick_i(mii_tick_i),
  .transmitted_symbol_a_i(transmitted_symbol_a_i),
  .transmitted_symbol_b_i(transmitted_symbol_b_i), .tx_sym_a_o(tx_sym_a_o),
  .tx_sym_b_o(tx_sym_b_o), .tx_en_o(tx_en_o), .rem_rcvr_ok_o(rem_rcvr_ok_o),
  .scr_status_o(scr_status_o), .rx_clk_recovered_o(rx_clk_recovered_o), .rxd_o(rxd_o),
  .tribit_valid_o(tribit_valid_o), .rx_er_o(rx_er_o));
